// ### verilog/ext_bus_map.svh
// timing constants and port and timer settings for the multiplexed external bus timing block
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define CLOCKS_PER_CYCLE 3'd4
`define SLOW_TICK_CLOCKS 4'd12
`define FAST_TICK_CLOCKS 4'd4
`define DATA_MOVE_CYCLES 3'd2
`define DIRECT_MOVE_CYCLES 3'd3
`define MAX_INSTR_CYCLES 3'd5
`define PORT_RESET_VALUE 8'hff
`define NUM_TIMERS 3
`endif

// ### verilog/ext_bus_pkg.sv
// types shared by the external bus timing block
package ext_bus_pkg;
    typedef enum logic [1:0] {OP_INTERNAL, OP_FETCH, OP_DATA_READ, OP_DATA_WRITE} bus_op_t;
    typedef enum {PH_ADDR, PH_LATCH, PH_STROBE, PH_END} phase_t;
endpackage

// ### verilog/ext_bus_timing.sv
// machine-cycle sequencer, multiplexed bus port and timer tick generator
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module ext_bus_timing
    import ext_bus_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // core request, sampled at the start of each op; addr_low at the start of each machine cycle
    input wire logic [1:0] op_kind,
    input wire logic [2:0] op_cycles,
    input wire logic [7:0] addr_low,
    input wire logic [7:0] write_data,
    input wire logic [2:0] fast_timer_sel,
    input wire logic external_access_strap_n,
    input wire logic [7:0] muxed_bus_port_in,
    output logic [7:0] muxed_bus_port_out,
    output logic [7:0] muxed_bus_port_oe,
    output logic address_latch_strobe,
    output logic program_store_strobe_n,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic cycle_start,
    output logic op_done,
    output logic [`NUM_TIMERS-1:0] timer_tick,
    output logic strap_fault
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] port_meta_q, port_sync_q;
    logic strap_meta_q, strap_sync_q;
    logic [2:0] fast_meta_q, fast_sync_q;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_meta_q <= `PORT_RESET_VALUE;
            port_sync_q <= `PORT_RESET_VALUE;
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
            fast_meta_q <= 3'h0;
            fast_sync_q <= 3'h0;
        end
        else if (clk_en)
        begin
            port_meta_q <= muxed_bus_port_in;
            port_sync_q <= port_meta_q;
            strap_meta_q <= external_access_strap_n;
            strap_sync_q <= strap_meta_q;
            fast_meta_q <= fast_timer_sel;
            fast_sync_q <= fast_meta_q;
        end
    end

    // ------------------------------------------------------------
    // machine cycle phase: four clocks per cycle
    // ------------------------------------------------------------
    phase_t phase_q, phase_d;
    bus_op_t op_q;
    logic [2:0] left_q;
    logic [7:0] wdata_q;
    always_comb
    begin
        unique case (phase_q)
            PH_ADDR: phase_d = PH_LATCH;
            PH_LATCH: phase_d = PH_STROBE;
            PH_STROBE: phase_d = PH_END;
            PH_END: phase_d = PH_ADDR;
        endcase
    end

    wire new_cycle = (phase_q == PH_END);
    wire last_cycle = (left_q <= 3'd1);
    wire take_op = new_cycle && last_cycle;
    // cycle count clamped to one..five so timing cannot run away
    wire [2:0] req_cycles = (op_cycles == 3'd0) ? 3'd1 :
        (op_cycles > `MAX_INSTR_CYCLES) ? `MAX_INSTR_CYCLES : op_cycles;
    // a data move cannot be shorter than two machine cycles
    wire is_data_req = (op_kind == OP_DATA_READ) || (op_kind == OP_DATA_WRITE);
    wire [2:0] eff_cycles = (is_data_req && req_cycles < `DATA_MOVE_CYCLES) ?
        `DATA_MOVE_CYCLES : req_cycles;
    wire is_data = (op_q == OP_DATA_READ) || (op_q == OP_DATA_WRITE);
    wire is_ext = (op_q != OP_INTERNAL);
    wire [2:0] left_d = take_op ? eff_cycles : (new_cycle ? left_q - 3'd1 : left_q);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= PH_ADDR;
            op_q <= OP_INTERNAL;
            left_q <= 3'd0;
            wdata_q <= 8'h00;
        end
        else if (clk_en)
        begin
            phase_q <= phase_d;
            left_q <= left_d;
            if (take_op)
            begin
                // bus timing only; the core keeps its own status effects
                op_q <= bus_op_t'(op_kind);
                wdata_q <= write_data;
            end
        end
    end

    // ------------------------------------------------------------
    // bus pin timing; values are registered one clock ahead
    // ------------------------------------------------------------
    // strobe high in the first clock of every cycle: one pulse per cycle
    wire ale_d = (phase_d == PH_ADDR);
    // program strobe only low in the late half of a fetch, never on data
    wire program_store_strobe_n_low = (op_q == OP_FETCH) &&
        (phase_d == PH_STROBE || phase_d == PH_END);
    // the address phase belongs to the op about to start, not the one that is ending;
    // op_q only turns over at that same edge, so it would be one op late here
    wire ext_next = take_op ? (op_kind != OP_INTERNAL) : is_ext;
    wire drive_addr = (phase_d == PH_ADDR) && ext_next;
    wire drive_data = (op_q == OP_DATA_WRITE) && (phase_d != PH_ADDR);
    // port pins come only from bus cycles, never from a software latch
    wire [7:0] port_d = drive_addr ? addr_low : (drive_data ? wdata_q : `PORT_RESET_VALUE);
    wire [7:0] oe_d = (drive_addr || drive_data) ? 8'hff : 8'h00;
    wire capture = (phase_q == PH_END) && (op_q == OP_FETCH || op_q == OP_DATA_READ);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            address_latch_strobe <= 1'b1;
            program_store_strobe_n <= 1'b1;
            muxed_bus_port_out <= `PORT_RESET_VALUE;
            muxed_bus_port_oe <= 8'h00;
            read_data <= 8'h00;
            read_valid <= 1'b0;
            cycle_start <= 1'b0;
            op_done <= 1'b0;
            strap_fault <= 1'b0;
        end
        else if (clk_en)
        begin
            address_latch_strobe <= ale_d;
            program_store_strobe_n <= !program_store_strobe_n_low;
            muxed_bus_port_out <= port_d;
            muxed_bus_port_oe <= oe_d;
            read_valid <= capture;
            if (capture)
                read_data <= port_sync_q;
            cycle_start <= ale_d;
            op_done <= new_cycle && last_cycle && is_ext;
            strap_fault <= strap_sync_q;
        end
    end

    // ------------------------------------------------------------
    // timer ticks: twelve clocks after reset, four when selected
    // ------------------------------------------------------------
    logic [3:0] presc_q [`NUM_TIMERS];
    logic [`NUM_TIMERS-1:0] tick_wrap;
    genvar t;
    generate
        for (t = 0; t < `NUM_TIMERS; t++)
        begin : g_tick
            wire [3:0] limit = fast_sync_q[t] ? `FAST_TICK_CLOCKS : `SLOW_TICK_CLOCKS;
            // >= rather than == so a switch from slow to fast never overshoots
            assign tick_wrap[t] = (presc_q[t] >= limit - 4'd1);
        end
    endgenerate

    // one process owns every prescaler and the whole tick vector
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `NUM_TIMERS; i++)
                presc_q[i] <= 4'd0;
            timer_tick <= '0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < `NUM_TIMERS; i++)
                presc_q[i] <= tick_wrap[i] ? 4'd0 : presc_q[i] + 4'd1;
            timer_tick <= tick_wrap;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PROGRAM_STORE_STROBE_N_DATA: assert property (@(posedge clock) disable iff (!arst_n)
        is_data |-> program_store_strobe_n) else $error("program strobe low on data move");
    AST_ALE_ONE_PER_CYCLE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && $rose(address_latch_strobe)) ##1 clk_en [*3] ##1 clk_en
        |-> $rose(address_latch_strobe)) else $error("strobe period not four clocks");
    AST_ALE_WIDTH: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && $rose(address_latch_strobe)) ##1 clk_en |-> !address_latch_strobe)
        else $error("strobe wider than one clock");
    AST_ADDR_ON_ALE: assert property (@(posedge clock) disable iff (!arst_n)
        (address_latch_strobe && muxed_bus_port_oe != 8'h00) |-> muxed_bus_port_oe == 8'hff)
        else $error("partial address drive");
    AST_FETCH_NO_DRIVE: assert property (@(posedge clock) disable iff (!arst_n)
        !program_store_strobe_n |-> muxed_bus_port_oe == 8'h00)
        else $error("port driven during fetch");
    AST_PROGRAM_STORE_STROBE_N_AFTER_ALE: assert property (@(posedge clock) disable iff (!arst_n)
        $fell(program_store_strobe_n) |-> !address_latch_strobe)
        else $error("program strobe fell before latch");
    AST_PORT_IDLE_HIGH: assert property (@(posedge clock) disable iff (!arst_n)
        muxed_bus_port_oe == 8'h00 |-> muxed_bus_port_out == `PORT_RESET_VALUE)
        else $error("port value without bus cycle");
    AST_LEFT_RANGE: assert property (@(posedge clock) disable iff (!arst_n)
        left_q <= `MAX_INSTR_CYCLES) else $error("instruction over five cycles");
    AST_TICK_SLOW: assert property (@(posedge clock) disable iff (!arst_n)
        (!fast_sync_q[0] && !$past(fast_sync_q[0]) && presc_q[0] > 4'd0 && clk_en)
        |-> presc_q[0] < `SLOW_TICK_CLOCKS) else $error("slow prescale out of range");

    // ------------------------------------------------------------
    // checks: strobe and port phases
    // ------------------------------------------------------------
    AST_PROGRAM_STORE_STROBE_N_TWO_CLOCKS: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && $fell(program_store_strobe_n)) |=> !program_store_strobe_n)
        else $error("program strobe low for one clock only");
    AST_FETCH_STROBE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && op_q == OP_FETCH && phase_q == PH_LATCH)
        |=> !program_store_strobe_n)
        else $error("fetch without program strobe");
    AST_PROGRAM_STORE_STROBE_N_IDLE_ALE: assert property (@(posedge clock) disable iff (!arst_n)
        address_latch_strobe |-> program_store_strobe_n)
        else $error("program strobe low during address phase");
    AST_DATA_DRIVE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && op_q == OP_DATA_WRITE && phase_q != PH_END)
        |=> (muxed_bus_port_oe == 8'hff && muxed_bus_port_out == wdata_q))
        else $error("write data not driven after address phase");
    AST_READ_RELEASE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && (op_q == OP_FETCH || op_q == OP_DATA_READ) && phase_q != PH_END)
        |=> muxed_bus_port_oe == 8'h00)
        else $error("port not released for read");
    AST_ADDR_VALUE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && phase_q == PH_END && ext_next)
        |=> (muxed_bus_port_oe == 8'hff && muxed_bus_port_out == $past(addr_low)))
        else $error("address byte missing in address phase");
    AST_OE_WHOLE: assert property (@(posedge clock) disable iff (!arst_n)
        muxed_bus_port_oe == 8'h00 || muxed_bus_port_oe == 8'hff)
        else $error("port enable split across bits");
    AST_CAPTURE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && capture)
        |=> (read_valid && read_data == $past(port_sync_q)))
        else $error("read byte not captured");

    // ------------------------------------------------------------
    // checks: sequencing, timers and clock enable
    // ------------------------------------------------------------
    AST_LEFT_LOADED: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && take_op)
        |=> (left_q >= 3'd1 && left_q <= `MAX_INSTR_CYCLES))
        else $error("op length outside one to five cycles");
    AST_DATA_MIN: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && take_op && is_data_req) |=> left_q >= `DATA_MOVE_CYCLES)
        else $error("data move shorter than two cycles");
    AST_DIRECT_MOVE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && take_op && op_kind == OP_INTERNAL && op_cycles == `DIRECT_MOVE_CYCLES)
        |=> left_q == `DIRECT_MOVE_CYCLES)
        else $error("direct move not three cycles");
    AST_TICK_PULSE: assert property (@(posedge clock) disable iff (!arst_n)
        (clk_en && tick_wrap[0]) |=> (timer_tick[0] && presc_q[0] == 4'd0))
        else $error("timer tick missing at wrap");
    AST_HOLD_FROZEN: assert property (@(posedge clock) disable iff (!arst_n)
        !clk_en |=> ($stable(address_latch_strobe) && $stable(muxed_bus_port_oe)))
        else $error("state moved while clock enable low");
endmodule // ext_bus_timing

// ### bench/ext_mem_model.sv
// outside address latch plus memory that answers with a byte tied to the latched address
`timescale 1ns/1ns
module ext_mem_model (
    input wire logic [7:0] pin,
    input wire logic ale,
    output logic [7:0] drive
);
    logic [7:0] latch_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    // transparent while the strobe is high, holds from its fall
    always @*
        if (ale)
            latch_q = pin;
    // released bus shows the inverse of the last byte, never a stale copy
    always @(posedge ale)
        last_q <= latch_q ^ 8'h5a;
    assign drive = ale ? ~last_q : (latch_q ^ 8'h5a);
endmodule // ext_mem_model

// ### bench/tb.sv
// self-checking bench for the external bus timing block
`timescale 1ns/1ns
module tb;
    import ext_bus_pkg::*;
    logic clock = 0, arst_n = 0, clk_en = 1, strap = 0, steady = 0, ale, program_store_strobe_n_n, rv, cs, done, sf;
    logic [1:0] kind = 0;
    logic [2:0] cyc = 1, fsel = 0, tick;
    logic [7:0] addr = 0, wdat = 0, pin, drv, out, oe, rd;
    int failures = 0, total_checks = 0, cycles = 0, ph = 0, pl = 0, dc = 0, len = 4;
    int tc[3];
    bit seen[3];
    bit dseen;
    int lens[$] = '{0, 3, 5, 7};
    assign pin = (oe & out) | (~oe & drv);
    ext_bus_timing ext_bus_timing_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .op_kind(kind), .op_cycles(cyc), .addr_low(addr), .write_data(wdat),
        .fast_timer_sel(fsel), .external_access_strap_n(strap), .muxed_bus_port_in(pin),
        .muxed_bus_port_out(out), .muxed_bus_port_oe(oe), .address_latch_strobe(ale),
        .program_store_strobe_n(program_store_strobe_n_n), .read_data(rd), .read_valid(rv), .cycle_start(cs),
        .op_done(done), .timer_tick(tick), .strap_fault(sf));
    ext_mem_model ext_mem_model_i (.pin(pin), .ale(ale), .drive(drv));
    initial
    begin
        forever #25 clock = ~clock;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %0t %h %h", $time, s, e);
        end
    endtask
    task end_of_test;
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // --------------------------------------------------------
    // monitor: values seen at an enabled edge are the settled state
    // --------------------------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            failures++;
            end_of_test();
        end
        if (arst_n && clk_en)
        begin
            ph++;
            dc++;
            if (!program_store_strobe_n_n)
                pl++;
            if (ale)
            begin
                if (steady)
                begin
                    chk(8'(ph), 8'd4);
                    chk(8'(pl), (kind == OP_FETCH) ? 8'd2 : 8'd0);
                    if (kind != OP_INTERNAL)
                        chk(out & oe, addr);
                end
                ph = 0;
                pl = 0;
            end
            if (steady)
                chk({7'h00, cs}, {7'h00, ale});
            if (steady && kind == OP_INTERNAL)
                chk(oe, 8'h00);
            if (steady && rv && (kind == OP_FETCH || kind == OP_DATA_READ))
                chk(rd, addr ^ 8'h5a);
            if (done && kind != OP_INTERNAL)
            begin
                if (steady && dseen)
                    chk(8'(dc), 8'(len));
                dseen = steady;
                dc = 0;
            end
            for (int t = 0; t < 3; t++)
            begin
                tc[t]++;
                if (tick[t])
                begin
                    if (seen[t] && steady)
                        chk(8'(tc[t]), fsel[t] ? 8'd4 : 8'd12);
                    seen[t] = steady;
                    tc[t] = 0;
                end
            end
        end
    end
    task rst;
        arst_n = 0;
        repeat (5) @(negedge clock);
        chk({ale, program_store_strobe_n_n, 6'h00}, 8'hc0);
        chk(out | oe, 8'hff);
        arst_n = 1;
    endtask
    task blk(input int k, input int c);
        int e;
        @(negedge clock);
        steady = 0;
        kind = k[1:0];
        cyc = c[2:0];
        addr = 8'($urandom);
        wdat = 8'($urandom);
        fsel = 3'($urandom);
        e = (c == 0) ? 1 : (c > 5) ? 5 : c;
        if (k >= 2 && e < 2)
            e = 2;
        len = 4 * e;
        repeat (60) @(negedge clock);
        steady = 1;
        repeat (100) @(negedge clock) clk_en = ($urandom % 4) != 0;
        clk_en = 1;
    endtask
    initial
    begin
        void'($urandom(32'hf3835d8c));
        rst();
        for (int k = 0; k < 4; k++)
            foreach (lens[i])
                blk(k, lens[i]);
        // strap held low by the system; a high strap must be flagged
        @(negedge clock) strap = 1;
        repeat (6) @(negedge clock);
        chk({7'h00, sf}, 8'h01);
        strap = 0;
        steady = 0;
        rst();
        blk(1, 1);
        end_of_test();
    end
endmodule // tb
